// ### src/gdfc_counter.sv
`timescale 1ns/1ns
`include "gdfc_regs.svh"

// What this block does
// - Divide reference into 0.1, 1, 10 s ticks.
// - Reference from internal or external source.
// - Time-base pulse opens closed main gate.
// - Open gate passes input pulses to decades.
// - Next time-base pulse closes main gate.
// - Closing gate shuts time-base gate too.
// - Hold count for adjustable display time.
// - Timer expiry clears decades, reopens time-base gate.
// - Infinite display suppresses the clear pulse.
// - Manual mode: gate follows released button.
// - Manual close starts normal display cycle.
// - Aux gate and reset in; carry, reset out.
// - Each decade is one-hot ring of ten.
// - Decade carries on nine-to-zero step.
// - Zero-setting forces digit zero, blocks carry out.
// - One clear zeroes all decades together.
module gdfc_counter #(
  parameter int NUM_DIGITS = `GDFC_NUM_DIGITS,
  parameter int CLK_HZ = 100000000,
  parameter int CLR_CYCLES = `GDFC_CLR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_ref,
  input wire logic ext_ref,
  input wire logic sig_in,
  input wire logic aux_gate,
  input wire logic aux_gate_en,
  input wire logic aux_reset,
  output logic carry_out,
  output logic reset_out,
  output logic gate_open,
  output gdfc_pkg::gdfc_digit_type digits [NUM_DIGITS]
);
  import gdfc_pkg::*;

  // ---------------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------------
  // Clock cycles per millisecond of display time.
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  logic [6:0] ctrl; // Select, infinite, ext ref, ext gate, button, reset.
  logic [6:0] next_ctrl; // Next control value.
  logic [15:0] disp_ms; // Display time in milliseconds.
  logic [15:0] next_disp_ms; // Next display time.
  logic [31:0] next_prdata; // Next read data.
  logic next_pslverr; // Next error answer.
  logic next_pready; // Next ready.
  logic wr_en; // Write access phase.
  logic mrst_pulse; // Manual reset pulse from software.
  logic [15:0] disp_clamped; // Display time limited to its range.
  gdfc_phase_type phase; // Measurement phase.
  logic tb_gate; // Time-base gate flip-flop.
  logic [19:0] bcd; // Low five digits as BCD for software.

  // Decode APB accesses; the answer comes after one wait state.
  always_comb begin
    wr_en = psel && penable && pwrite && pready;
    next_ctrl = ctrl;
    next_ctrl[`GDFC_CTRL_MRST_BIT] = 1'b0;
    next_disp_ms = disp_ms;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel && penable && !pready) begin
      unique case (paddr)
        `GDFC_OFF_CTRL: begin
          next_prdata = {26'h000_0000, ctrl[5:0]};
        end
        `GDFC_OFF_DISP: begin
          next_prdata = {16'h0000, disp_ms};
        end
        `GDFC_OFF_STAT: begin
          next_prdata = {28'h000_0000, phase, gate_open, tb_gate};
          next_pslverr = pwrite;
        end
        `GDFC_OFF_COUNT: begin
          next_prdata = {12'h000, bcd};
          next_pslverr = pwrite;
        end
        default: begin
          // Unmapped addresses answer with an error.
          next_pslverr = 1'b1;
        end
      endcase
    end
    // Writes land on the edge that completes the transfer.
    if (wr_en && paddr == `GDFC_OFF_CTRL) begin
      next_ctrl = pwdata[6:0];
    end
    if (wr_en && paddr == `GDFC_OFF_DISP) begin
      next_disp_ms = pwdata[15:0];
    end
    mrst_pulse = ctrl[`GDFC_CTRL_MRST_BIT];
    if (disp_ms < 16'(`GDFC_DISP_MIN_MS)) begin
      disp_clamped = 16'(`GDFC_DISP_MIN_MS);
    end else if (disp_ms > 16'(`GDFC_DISP_MAX_MS)) begin
      disp_clamped = 16'(`GDFC_DISP_MAX_MS);
    end else begin
      disp_clamped = disp_ms;
    end
  end

  // Register the bus state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 7'h00;
      disp_ms <= `GDFC_DISP_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      disp_ms <= next_disp_ms;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------------
  // Edge detection and time base
  // ---------------------------------------------------------------------
  logic [1:0] ref_q; // Reference history.
  logic [1:0] sig_q; // Input signal history.
  logic ref_pick; // Selected reference level.
  logic ref_tick; // One 100 kHz reference pulse.
  logic sig_tick; // One input signal pulse.
  logic [13:0] tb_div; // Divide-by-10000 prescaler.
  logic [13:0] next_tb_div; // Next prescaler value.
  logic [6:0] tb_dec; // Decades for 1 s and 10 s.
  logic [6:0] next_tb_dec; // Next decade divider value.
  logic tb_tick; // Selected time-base pulse.

  // Pick the reference source and form single-cycle rising-edge pulses.
  always_comb begin
    ref_pick = ctrl[`GDFC_CTRL_EXTREF_BIT] ? ext_ref : int_ref;
    ref_tick = ref_q[0] && !ref_q[1];
    sig_tick = sig_q[0] && !sig_q[1];
    next_tb_div = tb_div;
    next_tb_dec = tb_dec;
    if (ref_tick) begin
      if (tb_div == 14'(`GDFC_REF_HZ / 10 - 1)) begin
        next_tb_div = 14'h0000;
        next_tb_dec = (tb_dec == 7'(`GDFC_DECADE * `GDFC_DECADE - 1)) ?
          7'h00 : tb_dec + 7'h01;
      end else begin
        next_tb_div = tb_div + 14'h0001;
      end
    end
    tb_tick = 1'b0;
    if (ref_tick && tb_div == 14'(`GDFC_REF_HZ / 10 - 1)) begin
      unique case (ctrl[1:0])
        `GDFC_SEL_100MS: tb_tick = 1'b1;
        `GDFC_SEL_1S: tb_tick = (tb_dec % 7'h0a) == 7'h09;
        `GDFC_SEL_10S: tb_tick = tb_dec == 7'h63;
        `GDFC_SEL_MANUAL: tb_tick = 1'b0;
      endcase
    end
  end

  // Register the edge history and dividers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 2'b00;
      sig_q <= 2'b00;
      tb_div <= 14'h0000;
      tb_dec <= 7'h00;
    end else begin
      ref_q <= {ref_q[0], ref_pick};
      sig_q <= {sig_q[0], sig_in};
      tb_div <= next_tb_div;
      tb_dec <= next_tb_dec;
    end
  end

  // ---------------------------------------------------------------------
  // Gate sequencer
  // ---------------------------------------------------------------------
  gdfc_phase_type next_phase; // Next phase.
  logic next_tb_gate; // Next time-base gate.
  logic next_gate_open; // Next main gate.
  logic [31:0] hold_cnt; // Display and clear timer.
  logic [31:0] next_hold_cnt; // Next timer value.
  logic clear; // Zero-setting for all decades.
  logic next_reset_out; // Next reset output.
  logic manual; // Manual or external gating in force.
  logic man_level; // Gate level wanted in manual gating.

  // Step the gate flip-flops, display timer and clear pulse.
  always_comb begin
    manual = ctrl[1:0] == `GDFC_SEL_MANUAL || aux_gate_en;
    man_level = aux_gate_en ? aux_gate : !ctrl[`GDFC_CTRL_BTN_BIT];
    next_phase = phase;
    next_tb_gate = tb_gate;
    next_gate_open = gate_open;
    next_hold_cnt = hold_cnt;
    unique case (phase)
      GDFC_ARMED: begin
        if ((manual && man_level) || (!manual && tb_gate && tb_tick)) begin
          next_gate_open = 1'b1;
          next_phase = GDFC_COUNT;
        end
      end
      GDFC_COUNT: begin
        if ((manual && !man_level) || (!manual && tb_tick)) begin
          next_gate_open = 1'b0;
          next_tb_gate = 1'b0;
          next_hold_cnt = 32'(disp_clamped) * 32'(CYC_PER_MS);
          next_phase = GDFC_HOLD;
        end
      end
      GDFC_HOLD: begin
        if (!ctrl[`GDFC_CTRL_INF_BIT] && hold_cnt > 32'h0000_0001) begin
          next_hold_cnt = hold_cnt - 32'h0000_0001;
        end else if (!ctrl[`GDFC_CTRL_INF_BIT]) begin
          next_hold_cnt = 32'(CLR_CYCLES);
          next_phase = GDFC_CLEAR;
        end
      end
      GDFC_CLEAR: begin
        if (hold_cnt > 32'h0000_0001) begin
          next_hold_cnt = hold_cnt - 32'h0000_0001;
        end else begin
          next_tb_gate = 1'b1;
          next_phase = GDFC_ARMED;
        end
      end
    endcase
    if (aux_reset || mrst_pulse) begin
      next_gate_open = 1'b0;
      next_hold_cnt = 32'(CLR_CYCLES);
      next_phase = GDFC_CLEAR;
    end
    clear = phase == GDFC_CLEAR;
    next_reset_out = next_phase == GDFC_CLEAR;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= GDFC_ARMED;
      tb_gate <= 1'b1;
      gate_open <= 1'b0;
      hold_cnt <= 32'h0000_0000;
      reset_out <= 1'b0;
    end else begin
      phase <= next_phase;
      tb_gate <= next_tb_gate;
      gate_open <= next_gate_open;
      hold_cnt <= next_hold_cnt;
      reset_out <= next_reset_out;
    end
  end

  // ---------------------------------------------------------------------
  // Decade chain
  // ---------------------------------------------------------------------
  logic [NUM_DIGITS:0] step; // Advance into each decade.
  gdfc_digit_type next_digits [NUM_DIGITS]; // Next ring states.
  logic next_carry_out; // Next carry output.

  // Advance the rings; each carries on its nine-to-zero step.
  always_comb begin
    step[0] = gate_open && sig_tick;
    bcd = 20'h0_0000;
    for (int i = 0; i < NUM_DIGITS; i++) begin
      step[i + 1] = step[i] && digits[i][9];
      next_digits[i] = step[i] ? {digits[i][8:0], digits[i][9]} : digits[i];
      if (clear) begin
        next_digits[i] = 10'h001;
      end
      if (i < 5) begin
        for (int d = 0; d < 10; d++) begin
          if (digits[i][d]) begin
            bcd[i * 4 +: 4] = 4'(d);
          end
        end
      end
    end
    next_carry_out = step[NUM_DIGITS] && !clear;
  end

  // Register the rings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_DIGITS; i++) begin
        digits[i] <= 10'h001;
      end
      carry_out <= 1'b0;
    end else begin
      digits <= next_digits;
      carry_out <= next_carry_out;
    end
  end
endmodule : gdfc_counter

// ### src/gdfc_pkg.sv
package gdfc_pkg;
  // Phases of the measurement cycle.
  typedef enum logic [1:0] {
    GDFC_ARMED = 2'b00,
    GDFC_COUNT = 2'b01,
    GDFC_HOLD = 2'b11,
    GDFC_CLEAR = 2'b10
  } gdfc_phase_type;
  // One-hot digit of a decade.
  typedef logic [9:0] gdfc_digit_type;
endpackage : gdfc_pkg

// ### src/gdfc_regs.svh
`ifndef GDFC_REGS_SVH
`define GDFC_REGS_SVH

// Reference rate of the time base, in hertz.
`define GDFC_REF_HZ 100000
// Decade divide ratio of each time-base stage.
`define GDFC_DECADE 10
// Number of decade counters in the chain.
`define GDFC_NUM_DIGITS 5
// Display time bounds, in milliseconds.
`define GDFC_DISP_MIN_MS 500
`define GDFC_DISP_MAX_MS 5000
// Reset pulse length, in clock cycles.
`define GDFC_CLR_CYCLES 4
// Gate period selections.
`define GDFC_SEL_100MS 2'h0
`define GDFC_SEL_1S 2'h1
`define GDFC_SEL_10S 2'h2
`define GDFC_SEL_MANUAL 2'h3
// APB register byte offsets.
`define GDFC_OFF_CTRL 12'h000
`define GDFC_OFF_DISP 12'h004
`define GDFC_OFF_STAT 12'h008
`define GDFC_OFF_COUNT 12'h00c
// Reset values.
`define GDFC_CTRL_RST 32'h0000_0000
`define GDFC_DISP_RST 16'h01f4
// Control field positions.
`define GDFC_CTRL_SEL_LSB 0
`define GDFC_CTRL_INF_BIT 2
`define GDFC_CTRL_EXTREF_BIT 3
`define GDFC_CTRL_EXTGATE_BIT 4
`define GDFC_CTRL_BTN_BIT 5
`define GDFC_CTRL_MRST_BIT 6

`endif

// ### verification/gdfc_chk.sv
`timescale 1ns/1ns
// ------
// Checker
// ------
module gdfc_chk import gdfc_pkg::*; #(
  parameter int NUM_DIGITS = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic gate_open,
  input wire logic reset_out,
  input wire logic carry_out,
  input gdfc_pkg::gdfc_digit_type digits [NUM_DIGITS]
);
  logic all_hot; // Each decade lights one digit.
  logic all_zero; // Each decade shows zero.
  logic [9:0] rot; // Ones decade one step on.
  // Summarise the decades.
  always_comb begin
    all_hot = 1'b1;
    all_zero = 1'b1;
    for (int i = 0; i < NUM_DIGITS; i++) begin
      all_hot &= $onehot(digits[i]);
      all_zero &= (digits[i] == 10'h001);
    end
    rot = {digits[0][8:0], digits[0][9]};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bus_wait: assert property (psel && penable && !pready |=> pready)
    else $error("Answer late.");
  a_bus_pulse: assert property (pready |=> !pready)
    else $error("Answer too long.");
  a_digit_hot: assert property (all_hot)
    else $error("Decade not one-hot.");
  a_ones_step: assert property ($changed(digits[0]) && !reset_out |->
    digits[0] == $past(rot) || digits[0] == 10'h001)
    else $error("Ones decade skipped.");
  a_clear_len: assert property ($rose(reset_out) |->
    reset_out [*4] ##1 !reset_out) else $error("Clear length.");
  a_clear_zero: assert property (reset_out ##1 reset_out |-> all_zero)
    else $error("Clear left digits.");
  a_hold_still: assert property (!gate_open [*3] ##1
    (!gate_open && !reset_out && !$past(reset_out)) |-> $stable(digits[0]))
    else $error("Count moved while closed.");
  a_carry_wrap: assert property (carry_out |->
    digits[NUM_DIGITS-1] == 10'h001) else $error("Carry not at wrap.");
  c_gate: cover property ($rose(gate_open));
  c_clear: cover property ($rose(reset_out));
  c_close: cover property ($fell(gate_open));
  c_carry: cover property (carry_out);
endmodule : gdfc_chk
bind gdfc_counter gdfc_chk #(.NUM_DIGITS(NUM_DIGITS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .gate_open(gate_open), .reset_out(reset_out),
  .carry_out(carry_out), .digits(digits));

// ### verification/gdfc_counter_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module gdfc_counter_tb;
  import gdfc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, run_free = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, int_ref, ext_ref, sig_in;
  logic aux_gate = 1'b0, aux_gate_en = 1'b0, aux_reset = 1'b0;
  logic carry_out, reset_out, gate_open;
  gdfc_digit_type digits [5];
  gdfc_digit_type digits2 [2]; // Short chain, so its carry is reachable.
  logic use_ext = 1'b0, carry2;
  int carries = 0, k;
  int fails = 0, tests_run = 0, n;
  always #5 pclk = !pclk;
  gdfc_src src (.pclk(pclk), .run_free(run_free), .use_ext(use_ext),
    .int_ref(int_ref), .ext_ref(ext_ref), .sig_in(sig_in));
  gdfc_counter #(.CLK_HZ(1000)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_ref(int_ref), .ext_ref(ext_ref), .sig_in(sig_in),
    .aux_gate(aux_gate), .aux_gate_en(aux_gate_en), .aux_reset(aux_reset),
    .carry_out(carry_out), .reset_out(reset_out), .gate_open(gate_open),
    .digits(digits));
  // A two-decade copy shows the last-decade carry within the run.
  gdfc_counter #(.NUM_DIGITS(2), .CLK_HZ(1000)) dut2 (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .int_ref(int_ref), .ext_ref(ext_ref), .sig_in(sig_in),
    .aux_gate(aux_gate), .aux_gate_en(aux_gate_en), .aux_reset(aux_reset),
    .carry_out(carry2), .reset_out(), .gate_open(), .digits(digits2));
  // Counts carry pulses of the short chain.
  always @(posedge pclk) begin
    if (carry2 === 1'b1) begin
      carries <= carries + 1;
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d bad.", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fails++;
      report_and_stop();
    end
  endtask : apb
  // Waits for gate (w=0) or clear (w=1) to reach v; c counts cycles.
  task automatic wait_lvl(input int w, input logic v, output int c);
    for (c = 0; c < 30000; c++) begin
      @(posedge pclk);
      if ((w == 0 ? gate_open : reset_out) === v) return;
    end
    fails++;
    report_and_stop();
  endtask : wait_lvl
  // Compares all decades with a decimal value.
  task automatic chk_val(input int v);
    int p;
    p = 1;
    for (int i = 0; i < 5; i++) begin
      `CHK(digits[i], 10'h001 << ((v / p) % 10))
      p *= 10;
    end
  endtask : chk_val
  // Decodes the decades into a number.
  function automatic int dec();
    int s, p;
    s = 0;
    p = 1;
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 10; b++) begin
        if (digits[i][b] === 1'b1) s += b * p;
      end
      p *= 10;
    end
    return s;
  endfunction : dec
  // Closes the gate by hand after a burst, then waits for it.
  task automatic burst_close(input int k, input logic [31:0] c);
    src.pulses(k);
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h000, c);
    wait_lvl(0, 1'b0, n);
  endtask : burst_close
  // ------
  // Main sequence
  // ------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(gate_open, 1'b0)
    chk_val(0);
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(rd, 32'h0000_01f4)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h008, 32'h0000_0003);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h000, 32'h0000_0008);
    use_ext <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK(rd, 32'h0000_0008)
    $display("Test reset done.");
    run_free <= 1'b1;
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    `CHK(n > 19997 && n < 20003, 1'b1)
    run_free <= 1'b0;
    `CHK(dec() > 2497 && dec() < 2503, 1'b1)
    wait_lvl(1, 1'b1, n);
    `CHK(n > 495 && n < 510, 1'b1)
    wait_lvl(1, 1'b0, n);
    chk_val(0);
    $display("Test auto done.");
    apb(1'b1, 12'h000, 32'h0000_0027);
    apb(1'b1, 12'h000, 32'h0000_0007);
    wait_lvl(0, 1'b1, n);
    k = carries;
    burst_close(1009, 32'h0000_0027);
    n = 0;
    repeat (700) begin
      @(posedge pclk);
      if (reset_out === 1'b1) n++;
    end
    `CHK(n, 0)
    chk_val(1009);
    `CHK(carries - k, 10)
    `CHK(digits2[0], 10'h200)
    apb(1'b1, 12'h000, 32'h0000_0067);
    wait_lvl(1, 1'b1, n);
    wait_lvl(1, 1'b0, n);
    chk_val(0);
    apb(1'b1, 12'h004, 32'h0000_03e8);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(rd, 32'h0000_03e8)
    apb(1'b1, 12'h000, 32'h0000_0003);
    wait_lvl(0, 1'b1, n);
    burst_close(37, 32'h0000_0023);
    chk_val(37);
    wait_lvl(1, 1'b1, n);
    `CHK(n > 995 && n < 1010, 1'b1)
    wait_lvl(1, 1'b0, n);
    $display("Test manual done.");
    apb(1'b1, 12'h000, 32'h0000_0000);
    aux_gate_en <= 1'b1;
    aux_gate <= 1'b1;
    wait_lvl(0, 1'b1, n);
    src.pulses(5);
    repeat (4) @(posedge pclk);
    aux_gate <= 1'b0;
    wait_lvl(0, 1'b0, n);
    chk_val(5);
    aux_reset <= 1'b1;
    @(posedge pclk);
    aux_reset <= 1'b0;
    wait_lvl(1, 1'b1, n);
    wait_lvl(1, 1'b0, n);
    chk_val(0);
    $display("Test aux done.");
    report_and_stop();
  end
endmodule : gdfc_counter_tb

// ### verification/gdfc_src.sv
`timescale 1ns/1ns
// ------
// Signal source and reference
// ------
module gdfc_src (
  input wire logic pclk,
  input wire logic run_free,
  input wire logic use_ext,
  output logic int_ref,
  output logic ext_ref,
  output logic sig_in
);
  logic burst = 1'b0; // Counted burst level.
  logic [2:0] ph = 3'h0; // Free-running phase.
  // Phase counter; ref rises every 2 cycles, signal every 8.
  always @(posedge pclk) begin
    ph <= ph + 3'h1;
  end
  // both references; only the chosen one runs, so a wrong pick stalls.
  assign int_ref = ph[0] & !use_ext;
  assign ext_ref = ph[0] & use_ext;
  assign sig_in = burst | (run_free & ph[2]);
  // Sends n pulses, two cycles high and two low.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      burst <= 1'b1;
      repeat (2) @(posedge pclk);
      burst <= 1'b0;
      @(posedge pclk);
    end
  endtask : pulses
endmodule : gdfc_src
